/* File: pkg/ufa_pkg.sv */
// Shared constants and state types for the UART flow, address and infrared extensions.
package ufa_pkg;
  localparam int OVERSAMPLE = 16;
  localparam int PAUSE_CHARS = 2;
  localparam logic [9:0] PAUSE_TICKS_PER_BIT = 10'(PAUSE_CHARS * OVERSAMPLE);
  localparam logic [3:0] CHAR_BITS_BASE = 4'h7;
  localparam logic [1:0] SFC_OFF = 2'h0;
  localparam logic [1:0] SFC_SINGLE = 2'h1;
  localparam logic [1:0] SFC_DOUBLE = 2'h2;
  localparam logic [1:0] SEL_RESUME1 = 2'h0;
  localparam logic [1:0] SEL_RESUME2 = 2'h1;
  localparam logic [1:0] SEL_PAUSE1 = 2'h2;
  localparam logic [1:0] SEL_PAUSE2 = 2'h3;
  localparam logic [7:0] CHAR_RST = 8'h00;
  localparam logic [6:0] TRIG_LVL0 = 7'h08;
  localparam logic [6:0] TRIG_LVL1 = 7'h10;
  localparam logic [6:0] TRIG_LVL2 = 7'h38;
  localparam logic [6:0] TRIG_LVL3 = 7'h3c;
  localparam logic [6:0] RESUME_LVL0 = 7'h00;
  localparam logic [6:0] RESUME_LVL1 = 7'h08;
  localparam logic [6:0] RESUME_LVL2 = 7'h10;
  localparam logic [6:0] RESUME_LVL3 = 7'h38;
  localparam int TAG_PE = 8;
  localparam int TAG_FE = 9;
  localparam int TAG_BK = 10;
  localparam int FIFO_W = 11;
  localparam logic [2:0] IR_W10_TICKS = 3'h3;
  localparam logic [2:0] IR_W11_TICKS = 3'h4;
  localparam logic [2:0] PARITY_FORCE0 = 3'h7;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_PEND = 2'b10
  } ufa_rx_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SECOND = 2'b10
  } ufa_tx_e;
endpackage

/* File: core/ufa_irda.sv */
// Infrared pulse encoder and decoder on the oversampling baud enable.
`timescale 1ns/1ps
module ufa_irda import ufa_pkg::*; #(
  parameter int TICKS_PER_BIT = OVERSAMPLE
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic baud_tick_i,
  input wire logic ir_mode_i,
  input wire logic ir_fast_i,
  input wire logic tx_bit_i,
  input wire logic tx_bit_start_i,
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  output logic rx_serial_o
);
  localparam int DW = $clog2(TICKS_PER_BIT);
  logic pulse_q, pulse_d;
  logic [2:0] pcnt_q, pcnt_d;
  logic prev_q, prev_d;
  logic low_q, low_d;
  logic [DW-1:0] dcnt_q, dcnt_d;
  logic tx_pin_q, tx_pin_d;
  logic rx_ser_q, rx_ser_d;
  logic [2:0] width;

  always_comb begin
    width = ir_fast_i ? IR_W11_TICKS : IR_W10_TICKS;
    pulse_d = pulse_q;
    pcnt_d = pcnt_q;
    if (tx_bit_start_i && !tx_bit_i) begin
      pulse_d = 1'b1;
      pcnt_d = 3'h0;
    end else if (pulse_q && baud_tick_i) begin
      if (pcnt_q == width - 3'h1) begin
        pulse_d = 1'b0;
      end else begin
        pcnt_d = pcnt_q + 3'h1;
      end
    end
    tx_pin_d = ir_mode_i ? pulse_d : tx_bit_i;
    prev_d = rx_pin_i;
    low_d = low_q;
    dcnt_d = dcnt_q;
    if (rx_pin_i && !prev_q) begin
      low_d = 1'b1;
      dcnt_d = '0;
    end else if (low_q && baud_tick_i) begin
      if (dcnt_q == DW'(TICKS_PER_BIT - 1)) begin
        low_d = 1'b0;
      end else begin
        dcnt_d = dcnt_q + DW'(1);
      end
    end
    rx_ser_d = ir_mode_i ? !low_d : rx_pin_i;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_q <= 1'b0;
      pcnt_q <= 3'h0;
      prev_q <= 1'b0;
      low_q <= 1'b0;
      dcnt_q <= '0;
      tx_pin_q <= 1'b1;
      rx_ser_q <= 1'b1;
    end else begin
      pulse_q <= pulse_d;
      pcnt_q <= pcnt_d;
      prev_q <= prev_d;
      low_q <= low_d;
      dcnt_q <= dcnt_d;
      tx_pin_q <= tx_pin_d;
      rx_ser_q <= rx_ser_d;
    end
  end

  assign tx_pin_o = tx_pin_q;
  assign rx_serial_o = rx_ser_q;

  a_ir_zero_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ir_mode_i && tx_bit_start_i && !tx_bit_i ##1 ir_mode_i |-> tx_pin_o)
    else $error("No infrared pulse for a zero bit.");
  a_ir_decode_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ir_mode_i && rx_pin_i && !prev_q ##1 ir_mode_i |-> !rx_serial_o)
    else $error("Light pulse not decoded into the serial stream.");
  a_ir_one_dark: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ir_mode_i && !pulse_q && !(tx_bit_start_i && !tx_bit_i) ##1 ir_mode_i |-> !tx_pin_o)
    else $error("Infrared output high without a zero bit.");
endmodule

/* File: core/ufa_core.sv */
// Software flow control, special character, multidrop address and infrared wrapper logic.
`timescale 1ns/1ps
module ufa_core import ufa_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic baud_tick_i,
  input wire logic char_wr_i,
  input wire logic [1:0] char_sel_i,
  input wire logic [7:0] char_wdata_i,
  input wire logic [1:0] word_len_i,
  input wire logic parity_en_i,
  input wire logic stop2_i,
  input wire logic [1:0] sfc_rx_mode_i,
  input wire logic [1:0] sfc_tx_mode_i,
  input wire logic pause_irq_en_i,
  input wire logic enh_gate_i,
  input wire logic special_det_i,
  input wire logic multidrop_i,
  input wire logic rx_enable_i,
  input wire logic flag_clear_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_par_bit_i,
  input wire logic rx_par_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_break_i,
  input wire logic [6:0] rx_fifo_level_i,
  input wire logic [1:0] rx_trig_sel_i,
  input wire logic host_tx_valid_i,
  input wire logic [7:0] host_tx_data_i,
  input wire logic tsr_ready_i,
  input wire logic tx_bit_i,
  input wire logic tx_bit_start_i,
  input wire logic ir_mode_i,
  input wire logic ir_fast_i,
  input wire logic rx_pin_i,
  output logic fifo_wr_o,
  output logic [FIFO_W-1:0] fifo_wdata_o,
  output logic lsr_irq_o,
  output logic host_tx_take_o,
  output logic tsr_load_o,
  output logic [7:0] tsr_data_o,
  output logic tx_suspended_o,
  output logic pause_flag_o,
  output logic irq_o,
  output logic tx_pin_o,
  output logic rx_serial_o
);
  logic [7:0] res1_q, res1_d, res2_q, res2_d, pau1_q, pau1_d, pau2_q, pau2_d;
  ufa_rx_e rx_st_q, rx_st_d;
  logic [FIFO_W-1:0] pend_q, pend_d, flush_word_q, flush_word_d, wdata_q, wdata_d;
  logic pend_pause_q, pend_pause_d, flush_q, flush_d, wr_q, wr_d, lsr_q, lsr_d;
  logic auto_en_q, auto_en_d, susp_q, susp_d, flag_q, flag_d, irq_q, irq_d;
  logic pause_hit, resume_hit, special_hit;
  logic [7:0] mask;
  logic md_norm, md_auto, fc_on;
  logic [FIFO_W-1:0] new_word;
  ufa_tx_e tx_st_q, tx_st_d;
  logic [9:0] dly_q, dly_d, pause_ticks;
  logic dly_run_q, dly_run_d, preq_q, preq_d, rreq_q, rreq_d, remote_q, remote_d;
  logic load_q, load_d, take_q, take_d;
  logic [7:0] tdata_q, tdata_d, sec_q, sec_d;
  logic [6:0] trig, resume;
  logic [3:0] char_bits;

  function automatic logic eq_wl(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    eq_wl = ((a ^ b) & m) == 8'h00;
  endfunction

  always_comb begin
    res1_d = res1_q;
    res2_d = res2_q;
    pau1_d = pau1_q;
    pau2_d = pau2_q;
    if (char_wr_i) begin
      if (char_sel_i == SEL_RESUME1) begin
        res1_d = char_wdata_i;
      end else if (char_sel_i == SEL_RESUME2) begin
        res2_d = char_wdata_i;
      end else if (char_sel_i == SEL_PAUSE1) begin
        pau1_d = char_wdata_i;
      end else begin
        pau2_d = char_wdata_i;
      end
    end
  end

  always_comb begin
    case (word_len_i)
      2'h0: mask = 8'h1f;
      2'h1: mask = 8'h3f;
      2'h2: mask = 8'h7f;
      default: mask = 8'hff;
    endcase
    md_norm = multidrop_i && enh_gate_i && !special_det_i;
    md_auto = multidrop_i && enh_gate_i && special_det_i;
    fc_on = (sfc_rx_mode_i != SFC_OFF) && !(multidrop_i && enh_gate_i);
    new_word = {rx_break_i, rx_frame_err_i, rx_par_err_i, rx_data_i};
    rx_st_d = rx_st_q;
    pend_d = pend_q;
    pend_pause_d = pend_pause_q;
    flush_d = 1'b0;
    flush_word_d = flush_word_q;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    lsr_d = 1'b0;
    auto_en_d = md_auto ? auto_en_q : 1'b0;
    susp_d = fc_on ? susp_q : 1'b0;
    pause_hit = 1'b0;
    resume_hit = 1'b0;
    special_hit = 1'b0;
    if (flush_q) begin
      wr_d = 1'b1;
      wdata_d = flush_word_q;
    end
    if (rx_valid_i) begin
      if (md_auto) begin
        if (rx_par_bit_i) begin
          if (eq_wl(rx_data_i, pau2_q, mask)) begin
            auto_en_d = 1'b1;
            wr_d = 1'b1;
            wdata_d = {rx_break_i, rx_frame_err_i, rx_par_bit_i, rx_data_i};
            lsr_d = 1'b1;
          end else begin
            auto_en_d = 1'b0;
          end
        end else if (auto_en_q) begin
          wr_d = 1'b1;
          wdata_d = new_word;
        end
      end else if (md_norm) begin
        if (rx_par_bit_i) begin
          wr_d = 1'b1;
          wdata_d = {rx_break_i, rx_frame_err_i, 1'b1, rx_data_i};
          lsr_d = 1'b1;
        end else if (rx_enable_i) begin
          wr_d = 1'b1;
          wdata_d = new_word;
        end
      end else if (fc_on && sfc_rx_mode_i == SFC_DOUBLE && rx_st_q == RX_PEND) begin
        rx_st_d = RX_IDLE;
        if (pend_pause_q && eq_wl(rx_data_i, pau2_q, mask)) begin
          pause_hit = 1'b1;
        end else if (!pend_pause_q && eq_wl(rx_data_i, res2_q, mask)) begin
          resume_hit = 1'b1;
        end else begin
          wr_d = 1'b1;
          wdata_d = pend_q;
          if (eq_wl(rx_data_i, pau1_q, mask) || eq_wl(rx_data_i, res1_q, mask)) begin
            rx_st_d = RX_PEND;
            pend_d = new_word;
            pend_pause_d = eq_wl(rx_data_i, pau1_q, mask);
          end else begin
            flush_d = 1'b1;
            flush_word_d = new_word;
            special_hit = special_det_i && eq_wl(rx_data_i, pau2_q, mask);
          end
        end
      end else if (fc_on && eq_wl(rx_data_i, pau1_q, mask)) begin
        if (sfc_rx_mode_i == SFC_DOUBLE) begin
          rx_st_d = RX_PEND;
          pend_d = new_word;
          pend_pause_d = 1'b1;
        end else begin
          pause_hit = 1'b1;
        end
      end else if (fc_on && eq_wl(rx_data_i, res1_q, mask)) begin
        if (sfc_rx_mode_i == SFC_DOUBLE) begin
          rx_st_d = RX_PEND;
          pend_d = new_word;
          pend_pause_d = 1'b0;
        end else begin
          resume_hit = 1'b1;
        end
      end else begin
        wr_d = 1'b1;
        wdata_d = new_word;
        special_hit = special_det_i && eq_wl(rx_data_i, pau2_q, mask);
      end
    end
    if (pause_hit) begin
      susp_d = 1'b1;
    end
    if (resume_hit) begin
      susp_d = 1'b0;
    end
    flag_d = flag_q;
    if (flag_clear_i || resume_hit) begin
      flag_d = 1'b0;
    end
    if ((pause_hit && pause_irq_en_i) || special_hit) begin
      flag_d = 1'b1;
    end
    irq_d = flag_d;
  end

  always_comb begin
    case (rx_trig_sel_i)
      2'h0: begin trig = TRIG_LVL0; resume = RESUME_LVL0; end
      2'h1: begin trig = TRIG_LVL1; resume = RESUME_LVL1; end
      2'h2: begin trig = TRIG_LVL2; resume = RESUME_LVL2; end
      default: begin trig = TRIG_LVL3; resume = RESUME_LVL3; end
    endcase
    char_bits = CHAR_BITS_BASE + {2'h0, word_len_i} + {3'h0, parity_en_i} + {3'h0, stop2_i};
    pause_ticks = 10'(PAUSE_TICKS_PER_BIT * {6'h00, char_bits});
    dly_d = dly_q;
    dly_run_d = dly_run_q;
    preq_d = preq_q;
    rreq_d = rreq_q;
    remote_d = remote_q;
    if (sfc_tx_mode_i == SFC_OFF) begin
      dly_run_d = 1'b0;
      preq_d = 1'b0;
      rreq_d = 1'b0;
      remote_d = 1'b0;
    end else if (!remote_q) begin
      if (rx_fifo_level_i >= trig) begin
        if (!dly_run_q) begin
          dly_run_d = 1'b1;
          dly_d = 10'h000;
        end else if (baud_tick_i) begin
          if (dly_q == pause_ticks - 10'h001) begin
            dly_run_d = 1'b0;
            preq_d = 1'b1;
            remote_d = 1'b1;
          end else begin
            dly_d = dly_q + 10'h001;
          end
        end
      end else begin
        dly_run_d = 1'b0;
      end
    end else if (rx_fifo_level_i <= resume && !preq_q) begin
      rreq_d = 1'b1;
      remote_d = 1'b0;
    end
    tx_st_d = tx_st_q;
    load_d = 1'b0;
    take_d = 1'b0;
    tdata_d = tdata_q;
    sec_d = sec_q;
    if (tsr_ready_i && !load_q) begin
      case (tx_st_q)
        TX_IDLE: begin
          if (preq_q) begin
            load_d = 1'b1;
            tdata_d = pau1_q;
            sec_d = pau2_q;
            preq_d = 1'b0;
            if (sfc_tx_mode_i == SFC_DOUBLE) begin
              tx_st_d = TX_SECOND;
            end
          end else if (rreq_q) begin
            load_d = 1'b1;
            tdata_d = res1_q;
            sec_d = res2_q;
            rreq_d = 1'b0;
            if (sfc_tx_mode_i == SFC_DOUBLE) begin
              tx_st_d = TX_SECOND;
            end
          end else if (host_tx_valid_i && !susp_q) begin
            load_d = 1'b1;
            take_d = 1'b1;
            tdata_d = host_tx_data_i;
          end
        end
        TX_SECOND: begin
          load_d = 1'b1;
          tdata_d = sec_q;
          tx_st_d = TX_IDLE;
        end
        default: tx_st_d = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res1_q <= CHAR_RST;
      res2_q <= CHAR_RST;
      pau1_q <= CHAR_RST;
      pau2_q <= CHAR_RST;
      rx_st_q <= RX_IDLE;
      pend_q <= '0;
      pend_pause_q <= 1'b0;
      flush_q <= 1'b0;
      flush_word_q <= '0;
      wr_q <= 1'b0;
      wdata_q <= '0;
      lsr_q <= 1'b0;
      auto_en_q <= 1'b0;
      susp_q <= 1'b0;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      tx_st_q <= TX_IDLE;
      dly_q <= 10'h000;
      dly_run_q <= 1'b0;
      preq_q <= 1'b0;
      rreq_q <= 1'b0;
      remote_q <= 1'b0;
      load_q <= 1'b0;
      take_q <= 1'b0;
      tdata_q <= 8'h00;
      sec_q <= 8'h00;
    end else begin
      res1_q <= res1_d;
      res2_q <= res2_d;
      pau1_q <= pau1_d;
      pau2_q <= pau2_d;
      rx_st_q <= rx_st_d;
      pend_q <= pend_d;
      pend_pause_q <= pend_pause_d;
      flush_q <= flush_d;
      flush_word_q <= flush_word_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      lsr_q <= lsr_d;
      auto_en_q <= auto_en_d;
      susp_q <= susp_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      tx_st_q <= tx_st_d;
      dly_q <= dly_d;
      dly_run_q <= dly_run_d;
      preq_q <= preq_d;
      rreq_q <= rreq_d;
      remote_q <= remote_d;
      load_q <= load_d;
      take_q <= take_d;
      tdata_q <= tdata_d;
      sec_q <= sec_d;
    end
  end

  assign fifo_wr_o = wr_q;
  assign fifo_wdata_o = wdata_q;
  assign lsr_irq_o = lsr_q;
  assign host_tx_take_o = take_q;
  assign tsr_load_o = load_q;
  assign tsr_data_o = tdata_q;
  assign tx_suspended_o = susp_q;
  assign pause_flag_o = flag_q;
  assign irq_o = irq_q;

  ufa_irda #(.TICKS_PER_BIT(OVERSAMPLE)) u_irda (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .baud_tick_i(baud_tick_i),
    .ir_mode_i(ir_mode_i),
    .ir_fast_i(ir_fast_i && enh_gate_i),
    .tx_bit_i(tx_bit_i),
    .tx_bit_start_i(tx_bit_start_i),
    .rx_pin_i(rx_pin_i),
    .tx_pin_o(tx_pin_o),
    .rx_serial_o(rx_serial_o)
  );

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_pause_suspends: assert property (pause_hit && !resume_hit |=> tx_suspended_o)
    else $error("Pause match did not suspend the transmitter.");
  a_pause_flag_irq: assert property (pause_hit && pause_irq_en_i |=> pause_flag_o && irq_o)
    else $error("Pause match did not raise flag and interrupt.");
  a_resume_clears: assert property (resume_hit && !special_hit |=> !pause_flag_o && !tx_suspended_o)
    else $error("Resume match did not restart and clear.");
  a_flow_not_stored: assert property ((pause_hit || resume_hit) && !flush_q |=> !fifo_wr_o)
    else $error("Flow character was written to the FIFO.");
  a_host_held_off: assert property ($rose(host_tx_take_o) |-> !$past(tx_suspended_o))
    else $error("Host character loaded while suspended.");
  a_special_stored: assert property (special_hit |=> fifo_wr_o && pause_flag_o)
    else $error("Special character not stored or flagged.");
  a_auto_drop: assert property (md_auto && rx_valid_i && !auto_en_q && !rx_par_bit_i && !flush_q
    |=> !fifo_wr_o)
    else $error("Auto address mode stored a byte while disabled.");
  a_addr_tagged: assert property (md_norm && rx_valid_i && rx_par_bit_i
    |=> fifo_wr_o && fifo_wdata_o[TAG_PE] && lsr_irq_o)
    else $error("Address byte not stored with parity tag.");
  a_auto_enable: assert property (md_auto && rx_valid_i && rx_par_bit_i && eq_wl(rx_data_i, pau2_q, mask)
    |=> auto_en_q && fifo_wr_o && lsr_irq_o)
    else $error("Matching address did not enable the receiver.");
  a_load_spacing: assert property (tsr_load_o |-> !load_d)
    else $error("Two shift register loads in adjacent cycles.");
  a_pause_sent: assert property ($rose(preq_q) && tsr_ready_i && !load_q && tx_st_q == TX_IDLE
    |=> tsr_load_o && tsr_data_o == pau1_q)
    else $error("Pending pause character was not sent first.");

  c_pause_hit: cover property (pause_hit);
  c_resume_hit: cover property (resume_hit ##[1:1000] host_tx_take_o);
  c_auto_pause: cover property (tsr_load_o && tsr_data_o == pau1_q && remote_q);
  c_auto_addr: cover property ($rose(auto_en_q));
endmodule

/* File: bench/ufa_remote_node.sv */
// Behavioural far-side transmit shift register with its baud enable.
`timescale 1ns/1ps
module ufa_remote_node (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic tsr_load_i,
  input wire logic [7:0] tsr_data_i,
  output logic baud_tick_o,
  output logic tsr_ready_o,
  output logic tx_bit_o,
  output logic tx_bit_start_o
);
  logic [9:0] frame_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      baud_tick_o <= 1'b0;
      tsr_ready_o <= 1'b1;
      tx_bit_o <= 1'b1;
      tx_bit_start_o <= 1'b0;
      frame_q <= 10'h3ff;
      cnt_q <= 8'h00;
    end else begin
      baud_tick_o <= ~baud_tick_o;
      tx_bit_start_o <= 1'b0;
      if (tsr_load_i) begin
        frame_q <= {1'b1, tsr_data_i, 1'b0};
        cnt_q <= 8'h00;
        tsr_ready_o <= 1'b0;
        tx_bit_o <= 1'b0;
        tx_bit_start_o <= 1'b1;
      end else if (!tsr_ready_o && baud_tick_o) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == 8'h9f) begin
          tsr_ready_o <= 1'b1;
          tx_bit_o <= 1'b1;
        end else if (cnt_q[3:0] == 4'hf) begin
          frame_q <= frame_q >> 1;
          tx_bit_o <= frame_q[1];
          tx_bit_start_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: bench/uart_flow_address_irda_bench.sv */
// Self-checking bench for the flow, special character and multidrop logic.
`timescale 1ns/1ps
module uart_flow_address_irda_bench;
  import ufa_pkg::*;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, baud_tick_i, char_wr_i = 1'b0, parity_en_i = 1'b0, stop2_i = 1'b0;
  logic [1:0] char_sel_i = 2'h0, word_len_i = 2'h3, sfc_rx_mode_i = 2'h0, sfc_tx_mode_i = 2'h0, rx_trig_sel_i = 2'h0;
  logic [7:0] char_wdata_i = 8'h00, rx_data_i = 8'h00, host_tx_data_i = 8'h00, tsr_data_o;
  logic pause_irq_en_i = 1'b0, enh_gate_i = 1'b0, special_det_i = 1'b0, multidrop_i = 1'b0, rx_enable_i = 1'b0;
  logic flag_clear_i = 1'b0, rx_valid_i = 1'b0, rx_par_bit_i = 1'b0, rx_par_err_i = 1'b0, rx_frame_err_i = 1'b0;
  logic rx_break_i = 1'b0, host_tx_valid_i = 1'b0, tsr_ready_i, tx_bit_i, tx_bit_start_i;
  logic ir_mode_i = 1'b0, ir_fast_i = 1'b0, rx_pin_i = 1'b1;
  logic [6:0] rx_fifo_level_i = 7'h00;
  logic fifo_wr_o, lsr_irq_o, host_tx_take_o, tsr_load_o, tx_suspended_o, pause_flag_o, irq_o, tx_pin_o, rx_serial_o;
  logic [FIFO_W-1:0] fifo_wdata_o;
  logic [11:0] fifo_q[$];
  logic [7:0] tx_q[$];
  int failures = 0, check_count = 0, cycles = 0, n, i;
  int seed = 32'h8a6f0726;
  logic [7:0] d;
  logic [2:0] e;
  logic [2:0] w = 3'h3;
  logic ir_on = 1'b0;
  int pw = 0, pulses = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  ufa_core dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .baud_tick_i(baud_tick_i), .char_wr_i(char_wr_i),
    .char_sel_i(char_sel_i), .char_wdata_i(char_wdata_i), .word_len_i(word_len_i), .parity_en_i(parity_en_i),
    .stop2_i(stop2_i), .sfc_rx_mode_i(sfc_rx_mode_i), .sfc_tx_mode_i(sfc_tx_mode_i), .pause_irq_en_i(pause_irq_en_i),
    .enh_gate_i(enh_gate_i), .special_det_i(special_det_i), .multidrop_i(multidrop_i), .rx_enable_i(rx_enable_i),
    .flag_clear_i(flag_clear_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_par_bit_i(rx_par_bit_i),
    .rx_par_err_i(rx_par_err_i), .rx_frame_err_i(rx_frame_err_i), .rx_break_i(rx_break_i),
    .rx_fifo_level_i(rx_fifo_level_i), .rx_trig_sel_i(rx_trig_sel_i), .host_tx_valid_i(host_tx_valid_i),
    .host_tx_data_i(host_tx_data_i), .tsr_ready_i(tsr_ready_i), .tx_bit_i(tx_bit_i), .tx_bit_start_i(tx_bit_start_i),
    .ir_mode_i(ir_mode_i), .ir_fast_i(ir_fast_i), .rx_pin_i(rx_pin_i), .fifo_wr_o(fifo_wr_o),
    .fifo_wdata_o(fifo_wdata_o), .lsr_irq_o(lsr_irq_o), .host_tx_take_o(host_tx_take_o), .tsr_load_o(tsr_load_o),
    .tsr_data_o(tsr_data_o), .tx_suspended_o(tx_suspended_o), .pause_flag_o(pause_flag_o), .irq_o(irq_o),
    .tx_pin_o(tx_pin_o), .rx_serial_o(rx_serial_o));

  ufa_remote_node node (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tsr_load_i(tsr_load_o), .tsr_data_i(tsr_data_o),
    .baud_tick_o(baud_tick_i), .tsr_ready_o(tsr_ready_i), .tx_bit_o(tx_bit_i), .tx_bit_start_o(tx_bit_start_i));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask

  task automatic wr_char(input logic [1:0] sel, input logic [7:0] v);
    char_sel_i = sel;
    char_wdata_i = v;
    char_wr_i = 1'b1;
    tick(1);
    char_wr_i = 1'b0;
    tick(1);
  endtask

  task automatic rx(input logic [7:0] v, input logic par, input logic [2:0] err);
    rx_data_i = v;
    rx_par_bit_i = par;
    {rx_break_i, rx_frame_err_i, rx_par_err_i} = err;
    rx_valid_i = 1'b1;
    tick(1);
    rx_valid_i = 1'b0;
    tick(3);
  endtask

  task automatic wait_load();
    n = 0;
    while (tsr_load_o !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
  endtask

  always @(posedge clk_sys_i) begin
    if (nrst_i && fifo_wr_o === 1'b1) begin
      if (fifo_q.size() == 0) chk({lsr_irq_o, fifo_wdata_o}, ~{lsr_irq_o, fifo_wdata_o});
      else chk({lsr_irq_o, fifo_wdata_o}, fifo_q.pop_front());
    end
    if (nrst_i && tsr_load_o === 1'b1) begin
      if (tx_q.size() == 0) chk(tsr_data_o, ~tsr_data_o);
      else chk(tsr_data_o, tx_q.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  always @(posedge clk_sys_i) begin
    if (ir_on && tx_pin_o === 1'b1) begin
      pw++;
    end else if (pw > 0) begin
      pulses++;
      chk(pw >= 2 * w - 1 && pw <= 2 * w, 1'b1);
      pw = 0;
    end
  end

  initial begin
    tick(11);
    chk({tx_pin_o, rx_serial_o, tx_suspended_o, pause_flag_o, irq_o, fifo_wr_o}, 12'h030);
    tick(1);
    nrst_i = 1'b1;
    sfc_rx_mode_i = SFC_SINGLE;
    rx(8'h00, 1'b0, 3'h0);
    fifo_q.push_back(12'h001);
    rx(8'h01, 1'b0, 3'h0);
    sfc_rx_mode_i = SFC_OFF;
    wr_char(SEL_RESUME1, 8'h11);
    wr_char(SEL_RESUME2, 8'h12);
    wr_char(SEL_PAUSE1, 8'h13);
    wr_char(SEL_PAUSE2, 8'h5a);
    sfc_rx_mode_i = SFC_SINGLE;
    pause_irq_en_i = 1'b1;
    rx(8'h13, 1'b0, 3'h0);
    chk({tx_suspended_o, pause_flag_o, irq_o}, 12'h007);
    host_tx_data_i = 8'h41;
    host_tx_valid_i = 1'b1;
    tick(40);
    tx_q.push_back(8'h41);
    rx(8'h11, 1'b0, 3'h0);
    chk({tx_suspended_o, pause_flag_o}, 12'h000);
    host_tx_valid_i = 1'b0;
    sfc_rx_mode_i = SFC_DOUBLE;
    fifo_q.push_back(12'h013);
    fifo_q.push_back(12'h012);
    rx(8'h13, 1'b0, 3'h0);
    rx(8'h12, 1'b0, 3'h0);
    rx(8'h13, 1'b0, 3'h0);
    rx(8'h5a, 1'b0, 3'h0);
    chk(tx_suspended_o, 1'b1);
    rx(8'h11, 1'b0, 3'h0);
    rx(8'h12, 1'b0, 3'h0);
    chk(tx_suspended_o, 1'b0);
    sfc_rx_mode_i = SFC_SINGLE;
    word_len_i = 2'h0;
    rx(8'hf3, 1'b0, 3'h0);
    chk(tx_suspended_o, 1'b1);
    rx(8'hf1, 1'b0, 3'h0);
    chk(tx_suspended_o, 1'b0);
    word_len_i = 2'h3;
    sfc_rx_mode_i = SFC_OFF;
    special_det_i = 1'b1;
    fifo_q.push_back(12'h05a);
    rx(8'h5a, 1'b0, 3'h0);
    chk(pause_flag_o, 1'b1);
    flag_clear_i = 1'b1;
    tick(1);
    flag_clear_i = 1'b0;
    tick(1);
    chk(pause_flag_o, 1'b0);
    special_det_i = 1'b0;
    for (i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      e = 3'($random(seed));
      fifo_q.push_back({1'b0, e, d});
      rx(d, 1'b0, e);
    end
    multidrop_i = 1'b1;
    enh_gate_i = 1'b1;
    rx(8'h22, 1'b0, 3'h0);
    fifo_q.push_back(12'h933);
    rx(8'h33, 1'b1, 3'h1);
    rx_enable_i = 1'b1;
    fifo_q.push_back(12'h044);
    rx(8'h44, 1'b0, 3'h0);
    rx_enable_i = 1'b0;
    special_det_i = 1'b1;
    rx(8'h44, 1'b0, 3'h0);
    rx(8'h77, 1'b1, 3'h0);
    fifo_q.push_back(12'h95a);
    fifo_q.push_back(12'h055);
    rx(8'h5a, 1'b1, 3'h0);
    rx(8'h55, 1'b0, 3'h0);
    rx(8'h77, 1'b1, 3'h0);
    rx(8'h55, 1'b0, 3'h0);
    {multidrop_i, enh_gate_i, special_det_i} = 3'h0;
    sfc_tx_mode_i = SFC_SINGLE;
    {parity_en_i, stop2_i} = 2'($random(seed));
    rx_trig_sel_i = 2'h1;
    rx_fifo_level_i = TRIG_LVL1;
    tx_q.push_back(8'h13);
    wait_load();
    i = 64 * (10 + parity_en_i + stop2_i);
    chk(n >= i - 10 && n <= i + 40, 1'b1);
    rx_fifo_level_i = 7'h09;
    tick(400);
    rx_fifo_level_i = RESUME_LVL1;
    tx_q.push_back(8'h11);
    wait_load();
    tick(400);
    rx_pin_i = 1'b0;
    ir_mode_i = 1'b1;
    {ir_fast_i, enh_gate_i} = 2'($random(seed));
    tick(2);
    chk(rx_serial_o, 1'b1);
    rx_pin_i = 1'b1;
    tick(1);
    rx_pin_i = 1'b0;
    chk(rx_serial_o, 1'b0);
    tick(40);
    chk(rx_serial_o, 1'b1);
    w = (ir_fast_i && enh_gate_i) ? IR_W11_TICKS : IR_W10_TICKS;
    ir_on = 1'b1;
    d = 8'($random(seed));
    tx_q.push_back(d);
    host_tx_data_i = d;
    host_tx_valid_i = 1'b1;
    n = 0;
    while (host_tx_take_o !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    host_tx_valid_i = 1'b0;
    tick(400);
    chk(pulses, 1 + $countones(~d));
    chk(fifo_q.size() + tx_q.size(), 12'h000);
    summarize();
  end
endmodule
